// ---- rtl/ssel_pkg.sv ----
package ssel_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int POS_W = 20;
    localparam int RES_W = 19;
    localparam int PEND_W = 13;
    localparam int CNT_W = 16;
    localparam int TICK_W = 8;
    localparam int CODE_W = 4;

    // register map
    localparam logic [ADDR_W-1:0] CFG_ADDR = 8'h00;
    localparam logic [ADDR_W-1:0] STAT_ADDR = 8'h04;
    localparam logic [ADDR_W-1:0] RES_ADDR = 8'h08;
    localparam logic [ADDR_W-1:0] CNT_ADDR = 8'h0c;

    // configuration word fields
    localparam int CFG_TABLE_BIT = 0;
    localparam int CFG_CODE1_LSB = 4;
    localparam int CFG_CODE2_LSB = 8;
    localparam int CFG_MODE_BIT = 12;
    localparam int CFG_SMOOTH_BIT = 13;
    localparam int CFG_HIRES_BIT = 14;

    // status word fields, position sits in the low bits
    localparam int STAT_TIMING_BIT = 20;
    localparam int STAT_SMOOTH_BIT = 21;
    localparam int STAT_SEL_BIT = 22;
    localparam int STAT_BOTH_BIT = 23;
    localparam int STAT_RUNCHG_BIT = 24;
    localparam int STAT_CODE_LSB = 28;

    // position in fine units: one excitation cycle of ten full steps
    localparam logic [POS_W-1:0] CYCLE_UNITS = 20'h9c400;
    localparam logic [POS_W-1:0] HOME_POS = 20'h00000;
    localparam logic signed [PEND_W-1:0] SUB_STEPS = 13'sh0010;
    localparam logic signed [PEND_W-1:0] PEND_ZERO = 13'sh0000;
    localparam logic signed [PEND_W-1:0] PEND_ONE = 13'sh0001;
    localparam int SUB_SHIFT = 4;
    localparam logic [CODE_W-1:0] SMOOTH_MAX_PRI = 4'h6;
    localparam logic [CODE_W-1:0] SMOOTH_MAX_SEC = 4'h7;

    // microstep spacing while smoothing
    localparam int CLK_PERIOD_NS = 50;
    localparam int SUBSTEP_GAP_NS = 1000;
    localparam int SUBSTEP_GAP_CYC = (SUBSTEP_GAP_NS / CLK_PERIOD_NS) < 1 ? 1 : SUBSTEP_GAP_NS / CLK_PERIOD_NS;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SUBSTEP_GAP_CYC - 1);

    typedef enum logic {pulse_and_direction_mode, dual_pulse_line_mode} ssel_pmode_t;
    typedef enum logic {primary_resolution_table, secondary_resolution_table} ssel_table_t;

    typedef struct packed {
        logic hires;
        logic smooth_drive_enable;
        ssel_pmode_t pmode;
        logic [CODE_W-1:0] second_step_angle_code;
        logic [CODE_W-1:0] first_step_angle_code;
        ssel_table_t table_sel;
    } ssel_cfg_t;

    localparam ssel_cfg_t CFG_RST = '{hires: 1'b0, smooth_drive_enable: 1'b1, pmode: pulse_and_direction_mode,
        second_step_angle_code: 4'h0, first_step_angle_code: 4'h0, table_sel: primary_resolution_table};

    typedef struct packed {
        logic step_select;
        logic line_b;
        logic line_a;
    } ssel_pins_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } ssel_bus_req_t;

    // fine units per pulse for each code
    localparam logic [POS_W-1:0] INC_PRI [16] = '{20'h0fa00, 20'h07d00, 20'h06400, 20'h03e80, 20'h03200,
        20'h01f40, 20'h01900, 20'h00c80, 20'h00a00, 20'h00640, 20'h00500, 20'h00320, 20'h00280, 20'h00200,
        20'h00140, 20'h00100};
    localparam logic [POS_W-1:0] INC_SEC [16] = '{20'h27100, 20'h13880, 20'h09c40, 20'h07d00, 20'h04e20,
        20'h03e80, 20'h02710, 20'h01900, 20'h01388, 20'h00c80, 20'h009c4, 20'h00640, 20'h00500, 20'h004e2,
        20'h00280, 20'h00271};
    // steps per revolution at the standard base step angle
    localparam logic [RES_W-2:0] RES_PRI [16] = '{18'h001f4, 18'h003e8, 18'h004e2, 18'h007d0, 18'h009c4,
        18'h00fa0, 18'h01388, 18'h02710, 18'h030d4, 18'h04e20, 18'h061a8, 18'h09c40, 18'h0c350, 18'h0f424,
        18'h186a0, 18'h1e848};
    localparam logic [RES_W-2:0] RES_SEC [16] = '{18'h000c8, 18'h00190, 18'h00320, 18'h003e8, 18'h00640,
        18'h007d0, 18'h00c80, 18'h01388, 18'h01900, 18'h02710, 18'h03200, 18'h04e20, 18'h061a8, 18'h06400,
        18'h0c350, 18'h0c800};
endpackage

// ---- rtl/ssel_sync.sv ----
`timescale 1ns/1ns
module ssel_sync (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire ssel_pkg::ssel_pins_t pins_in,
    output ssel_pkg::ssel_pins_t pins_out
);
    import ssel_pkg::*;

    typedef struct packed {
        ssel_pins_t meta;
        ssel_pins_t stable;
    } ssel_sync_st_t;

    ssel_sync_st_t st;
    ssel_sync_st_t next_st;

    always_comb begin
        next_st.meta = pins_in;
        next_st.stable = st.meta;
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pins_out = st.stable;
endmodule

// ---- rtl/ssel_res_lut.sv ----
`timescale 1ns/1ns
module ssel_res_lut (
    input wire ssel_pkg::ssel_table_t table_in,
    input wire logic [ssel_pkg::CODE_W-1:0] code_in,
    input wire logic hires_in,
    output logic [ssel_pkg::POS_W-1:0] inc_out,
    output logic [ssel_pkg::RES_W-1:0] res_out,
    output logic smooth_ok_out
);
    import ssel_pkg::*;

    logic [RES_W-2:0] base_res;

    always_comb begin
        if (table_in == secondary_resolution_table) begin
            inc_out = INC_SEC[code_in];
            base_res = RES_SEC[code_in];
            smooth_ok_out = (code_in <= SMOOTH_MAX_SEC);
        end else begin
            inc_out = INC_PRI[code_in];
            base_res = RES_PRI[code_in];
            smooth_ok_out = (code_in <= SMOOTH_MAX_PRI);
        end
        // same divisions on a motor with half the base step angle
        res_out = hires_in ? {base_res, 1'b0} : {1'b0, base_res};
    end
endmodule

// ---- rtl/ssel_top.sv ----
`timescale 1ns/1ns
// Functional notes
// - the step angle comes from the table select together with the active 4-bit step-angle code.
// - the primary table maps codes 0 to f onto divisions 1 to 250, i.e. 500 to 125,000 steps per turn.
// - the secondary table maps codes 0 to f onto 200 to 51200 steps per turn.
// - two step-angle codes are held independently and are both set by each write of the configuration word.
// - the step select level picks the first code when low and the second when high.
// - in pulse and direction mode each pulse on line a steps in the direction that line b gives.
// - in dual pulse line mode line a steps forward and line b steps backward.
// - with smooth drive in force each pulse's step is split into 16 microsteps with no change to the pulses.
// - smooth drive applies only to codes 0 to 6 of the primary table or 0 to 7 of the secondary one.
// - beyond a division of 10 the smooth drive enable is ignored as if it were off.
// - smooth drive enable comes up enabled.
// - on the high-resolution motor the base angle is halved and the base resolution is 1000.
// - power-up puts the excitation at home, and the timing output is high whenever it is at home.
module ssel_top (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire ssel_pkg::ssel_bus_req_t bus_req_in,
    output logic [ssel_pkg::DATA_W-1:0] reg_rdata_out,
    input wire ssel_pkg::ssel_pins_t pins_in,
    output logic [ssel_pkg::POS_W-1:0] exc_pos_out,
    output logic timing_out,
    output logic smooth_active_out
);
    import ssel_pkg::*;

    typedef struct packed {
        ssel_cfg_t cfg;
        logic [DATA_W-1:0] rdata;
        logic prev_a;
        logic prev_b;
        logic prev_sel;
        logic [POS_W-1:0] pos;
        logic signed [PEND_W-1:0] pend;
        logic [POS_W-1:0] sub_inc;
        logic [TICK_W-1:0] tick;
        logic timing;
        logic smooth_act;
        logic both_err;
        logic run_chg;
        logic [CNT_W-1:0] step_cnt;
    } ssel_top_st_t;

    localparam ssel_top_st_t ST_RST = '{
        cfg: CFG_RST,
        rdata: '0,
        prev_a: 1'b0,
        prev_b: 1'b0,
        prev_sel: 1'b0,
        pos: HOME_POS,
        pend: PEND_ZERO,
        sub_inc: '0,
        tick: '0,
        timing: 1'b1,
        smooth_act: 1'b0,
        both_err: 1'b0,
        run_chg: 1'b0,
        step_cnt: '0
    };

    ssel_top_st_t st;
    ssel_top_st_t next_st;

    ssel_pins_t pins_s;
    logic [CODE_W-1:0] act_code;
    logic [POS_W-1:0] act_inc;
    logic [RES_W-1:0] act_res;
    logic act_smooth_ok;
    logic smooth_use;
    logic rise_a;
    logic rise_b;
    logic both_on;
    logic step_fwd;
    logic step_rev;
    logic direct;
    logic tick_hit;
    logic drain_fwd;
    logic drain_rev;
    logic moving;
    logic sel_moved;
    logic cfg_wr;
    logic stat_wr;
    logic both_set;
    logic run_set;
    logic signed [PEND_W-1:0] pend_add;
    logic [DATA_W-1:0] cfg_word;
    logic [DATA_W-1:0] stat_word;

    // forward move, wrapping at the end of the excitation cycle
    function automatic logic [POS_W-1:0] pos_fwd(input logic [POS_W-1:0] p, input logic [POS_W-1:0] d);
        logic [POS_W:0] s;
        s = {1'b0, p} + {1'b0, d};
        if (s >= {1'b0, CYCLE_UNITS}) begin
            s = s - {1'b0, CYCLE_UNITS};
        end
        return s[POS_W-1:0];
    endfunction

    // backward move, wrapping below home
    function automatic logic [POS_W-1:0] pos_rev(input logic [POS_W-1:0] p, input logic [POS_W-1:0] d);
        logic [POS_W-1:0] r;
        if (p >= d) begin
            r = p - d;
        end else begin
            r = p + CYCLE_UNITS - d;
        end
        return r;
    endfunction

    ssel_sync ssel_sync_inst (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .pins_in(pins_in),
        .pins_out(pins_s)
    );

    ssel_res_lut ssel_res_lut_inst (
        .table_in(st.cfg.table_sel),
        .code_in(act_code),
        .hires_in(st.cfg.hires),
        .inc_out(act_inc),
        .res_out(act_res),
        .smooth_ok_out(act_smooth_ok)
    );

    // the active code follows the synchronised select level
    assign act_code = pins_s.step_select ? st.cfg.second_step_angle_code : st.cfg.first_step_angle_code;

    always_comb begin
        next_st = st;
        next_st.rdata = '0;

        // edge detection on the synchronised pulse lines
        rise_a = pins_s.line_a & ~st.prev_a;
        rise_b = pins_s.line_b & ~st.prev_b;
        both_on = pins_s.line_a & pins_s.line_b;
        next_st.prev_a = pins_s.line_a;
        next_st.prev_b = pins_s.line_b;
        next_st.prev_sel = pins_s.step_select;

        step_fwd = 1'b0;
        step_rev = 1'b0;
        both_set = 1'b0;
        case (st.cfg.pmode)
            pulse_and_direction_mode: begin
                // line b high means forward
                step_fwd = rise_a & pins_s.line_b;
                step_rev = rise_a & ~pins_s.line_b;
            end
            dual_pulse_line_mode: begin
                // a pulse that meets the other line high is dropped
                step_fwd = rise_a & ~pins_s.line_b;
                step_rev = rise_b & ~pins_s.line_a;
                both_set = (rise_a | rise_b) & both_on;
            end
            default: begin
                step_fwd = 1'b0;
                step_rev = 1'b0;
            end
        endcase

        // smooth drive only inside the coarse part of either table
        smooth_use = st.cfg.smooth_drive_enable & act_smooth_ok;
        next_st.smooth_act = smooth_use;

        // free-running spacing of microsteps
        tick_hit = (st.tick == TICK_LAST);
        if (tick_hit) begin
            next_st.tick = '0;
        end else begin
            next_st.tick = st.tick + 1'b1;
        end

        direct = ~smooth_use & (step_fwd | step_rev);
        drain_fwd = tick_hit & ~direct & (st.pend > PEND_ZERO);
        drain_rev = tick_hit & ~direct & (st.pend < PEND_ZERO);

        // each smoothed pulse queues 16 microsteps of a sixteenth of its step
        pend_add = PEND_ZERO;
        if (smooth_use & step_fwd) begin
            pend_add = SUB_STEPS;
        end else if (smooth_use & step_rev) begin
            pend_add = -SUB_STEPS;
        end
        if (smooth_use & (step_fwd | step_rev)) begin
            next_st.sub_inc = act_inc >> SUB_SHIFT;
        end

        next_st.pend = st.pend + pend_add;
        if (drain_fwd) begin
            next_st.pend = st.pend + pend_add - PEND_ONE;
        end else if (drain_rev) begin
            next_st.pend = st.pend + pend_add + PEND_ONE;
        end

        // excitation position
        if (direct & step_fwd) begin
            next_st.pos = pos_fwd(st.pos, act_inc);
        end else if (direct & step_rev) begin
            next_st.pos = pos_rev(st.pos, act_inc);
        end else if (drain_fwd) begin
            next_st.pos = pos_fwd(st.pos, st.sub_inc);
        end else if (drain_rev) begin
            next_st.pos = pos_rev(st.pos, st.sub_inc);
        end
        next_st.timing = (next_st.pos == HOME_POS);

        if (step_fwd | step_rev) begin
            next_st.step_cnt = st.step_cnt + 1'b1;
        end

        // register port decode
        cfg_wr = bus_req_in.wr & (bus_req_in.addr == CFG_ADDR);
        stat_wr = bus_req_in.wr & (bus_req_in.addr == STAT_ADDR);
        if (cfg_wr) begin
            next_st.cfg.table_sel = ssel_table_t'(bus_req_in.wdata[CFG_TABLE_BIT]);
            next_st.cfg.first_step_angle_code = bus_req_in.wdata[CFG_CODE1_LSB +: CODE_W];
            next_st.cfg.second_step_angle_code = bus_req_in.wdata[CFG_CODE2_LSB +: CODE_W];
            next_st.cfg.pmode = ssel_pmode_t'(bus_req_in.wdata[CFG_MODE_BIT]);
            next_st.cfg.smooth_drive_enable = bus_req_in.wdata[CFG_SMOOTH_BIT];
            next_st.cfg.hires = bus_req_in.wdata[CFG_HIRES_BIT];
        end

        // a setting touched while microsteps are still queued is flagged
        moving = (st.pend != PEND_ZERO);
        sel_moved = pins_s.step_select ^ st.prev_sel;
        run_set = moving & (cfg_wr | sel_moved);

        // sticky flags clear on a written one; a new event wins
        next_st.both_err = (st.both_err & ~(stat_wr & bus_req_in.wdata[STAT_BOTH_BIT])) | both_set;
        next_st.run_chg = (st.run_chg & ~(stat_wr & bus_req_in.wdata[STAT_RUNCHG_BIT])) | run_set;

        cfg_word = '0;
        cfg_word[CFG_TABLE_BIT] = st.cfg.table_sel;
        cfg_word[CFG_CODE1_LSB +: CODE_W] = st.cfg.first_step_angle_code;
        cfg_word[CFG_CODE2_LSB +: CODE_W] = st.cfg.second_step_angle_code;
        cfg_word[CFG_MODE_BIT] = st.cfg.pmode;
        cfg_word[CFG_SMOOTH_BIT] = st.cfg.smooth_drive_enable;
        cfg_word[CFG_HIRES_BIT] = st.cfg.hires;

        stat_word = '0;
        stat_word[POS_W-1:0] = st.pos;
        stat_word[STAT_TIMING_BIT] = st.timing;
        stat_word[STAT_SMOOTH_BIT] = st.smooth_act;
        stat_word[STAT_SEL_BIT] = pins_s.step_select;
        stat_word[STAT_BOTH_BIT] = st.both_err;
        stat_word[STAT_RUNCHG_BIT] = st.run_chg;
        stat_word[STAT_CODE_LSB +: CODE_W] = act_code;

        if (bus_req_in.rd) begin
            case (bus_req_in.addr)
                CFG_ADDR: begin
                    next_st.rdata = cfg_word;
                end
                STAT_ADDR: begin
                    next_st.rdata = stat_word;
                end
                RES_ADDR: begin
                    next_st.rdata = {{(DATA_W-RES_W){1'b0}}, act_res};
                end
                CNT_ADDR: begin
                    next_st.rdata = {{(DATA_W-CNT_W){1'b0}}, st.step_cnt};
                end
                default: begin
                    next_st.rdata = '0;
                end
            endcase
        end
    end

    // reset puts the excitation at home with smooth drive enabled
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            st <= ST_RST;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata_out = st.rdata;
    assign exc_pos_out = st.pos;
    assign timing_out = st.timing;
    assign smooth_active_out = st.smooth_act;
endmodule

// ---- testbench/ssel_top_props.sv ----
`timescale 1ns/1ns
module ssel_top_props (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire ssel_pkg::ssel_bus_req_t bus_req_in,
    input wire logic [ssel_pkg::DATA_W-1:0] reg_rdata_out,
    input wire ssel_pkg::ssel_pins_t pins_in,
    input wire logic [ssel_pkg::POS_W-1:0] exc_pos_out,
    input wire logic timing_out,
    input wire logic smooth_active_out
);
    import ssel_pkg::*;
    logic [POS_W-1:0] prev_pos;
    logic [14:0] cfg_copy;
    logic [20:0] fwd;
    logic moved;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    always_ff @(posedge ref_clk_in) begin
        prev_pos <= exc_pos_out;
        if (!rst_b_in) begin
            cfg_copy <= 15'h2000;
        end else if (bus_req_in.wr && bus_req_in.addr == CFG_ADDR) begin
            cfg_copy <= bus_req_in.wdata[14:0] & 15'h7ff1;
        end
    end
    // forward distance of the last move, modulo one excitation cycle
    always_comb begin
        fwd = 21'(exc_pos_out) + 21'(CYCLE_UNITS) - 21'(prev_pos);
        if (fwd >= 21'(CYCLE_UNITS)) begin
            fwd = fwd - 21'(CYCLE_UNITS);
        end
    end
    assign moved = exc_pos_out != prev_pos;
    timing_at_home_a: assert property (timing_out == (exc_pos_out == HOME_POS))
        else $error("timing output disagrees with position");
    home_after_reset_a: assert property ($rose(rst_b_in) |-> exc_pos_out == HOME_POS && timing_out)
        else $error("position not home after reset");
    pos_in_cycle_a: assert property (exc_pos_out < CYCLE_UNITS)
        else $error("position outside one cycle");
    step_bounded_a: assert property (moved |-> fwd <= 21'd160000 || fwd >= 21'd480000)
        else $error("move larger than one step");
    sub_size_a: assert property (smooth_active_out && moved |-> fwd <= 21'd10000 || fwd >= 21'd630000)
        else $error("smooth move larger than a microstep");
    sub_spacing_a: assert property (smooth_active_out && moved |=> !moved [*8])
        else $error("microsteps too close");
    cfg_held_a: assert property (bus_req_in.rd && bus_req_in.addr == CFG_ADDR
        |=> (reg_rdata_out[14:0] & 15'h7ff1) == cfg_copy) else $error("config read back wrong");
    stat_pos_a: assert property (bus_req_in.rd && bus_req_in.addr == STAT_ADDR
        |=> reg_rdata_out[POS_W-1:0] == $past(exc_pos_out) && reg_rdata_out[STAT_TIMING_BIT] == $past(timing_out))
        else $error("status word wrong");
    res_span_a: assert property (bus_req_in.rd && bus_req_in.addr == RES_ADDR
        |=> reg_rdata_out inside {[32'd200:32'd250000]}) else $error("resolution out of range");
    cover property (smooth_active_out && moved);
    cover property ($rose(timing_out));
    cover property (bus_req_in.rd && bus_req_in.addr == STAT_ADDR);
endmodule

// ---- testbench/ssel_host.sv ----
`timescale 1ns/1ns
module ssel_host (
    input wire logic ref_clk_in,
    output ssel_pkg::ssel_pins_t pins_out
);
    import ssel_pkg::*;
    initial begin
        pins_out = '0;
    end
    // called only with the motor stopped
    task automatic set_select(input logic on);
        @(posedge ref_clk_in);
        pins_out.step_select <= on;
        repeat (4) @(posedge ref_clk_in);
    endtask
    // one step; hold stretches the high and low phases for a slow controller
    task automatic pulse(input logic dual, input logic fwd, input int hold);
        @(posedge ref_clk_in);
        if (!dual) begin
            pins_out.line_b <= fwd;
            repeat (3) @(posedge ref_clk_in);
        end
        if (!dual || fwd) begin
            pins_out.line_a <= 1'b1;
        end else begin
            pins_out.line_b <= 1'b1;
        end
        repeat (hold) @(posedge ref_clk_in);
        pins_out.line_a <= 1'b0;
        // line b always returns low so a later reset or mode change sees no stale rise
        pins_out.line_b <= 1'b0;
        repeat (hold) @(posedge ref_clk_in);
    endtask
    // faulty controller: raises the second line while the first is still high
    task automatic both_lines(input int hold);
        @(posedge ref_clk_in);
        pins_out.line_b <= 1'b1;
        repeat (hold) @(posedge ref_clk_in);
        pins_out.line_a <= 1'b1;
        repeat (hold) @(posedge ref_clk_in);
        pins_out.line_a <= 1'b0;
        pins_out.line_b <= 1'b0;
        repeat (hold) @(posedge ref_clk_in);
    endtask
endmodule

// ---- testbench/step_resolution_select_bench.sv ----
`timescale 1ns/1ns
module step_resolution_select_bench;
    import ssel_pkg::*;
    logic ref_clk_in;
    logic rst_b_in;
    ssel_bus_req_t bus_req_in;
    logic [DATA_W-1:0] reg_rdata_out;
    ssel_pins_t pins_in;
    logic [POS_W-1:0] exc_pos_out;
    logic timing_out;
    logic smooth_active_out;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int exp_pos;
    logic [DATA_W-1:0] rd_val;
    int res_tab [2][16] = '{'{500, 1000, 1250, 2000, 2500, 4000, 5000, 10000, 12500, 20000, 25000, 40000,
        50000, 62500, 100000, 125000}, '{200, 400, 800, 1000, 1600, 2000, 3200, 5000, 6400, 10000, 12800,
        20000, 25000, 25600, 50000, 51200}};
    ssel_top ssel_top_inst (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .bus_req_in(bus_req_in),
        .reg_rdata_out(reg_rdata_out), .pins_in(pins_in), .exc_pos_out(exc_pos_out),
        .timing_out(timing_out), .smooth_active_out(smooth_active_out));
    ssel_host ssel_host_inst (.ref_clk_in(ref_clk_in), .pins_out(pins_in));
    initial begin
        ref_clk_in = 1'b0;
        forever #25 ref_clk_in = ~ref_clk_in;
    end
    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic close_out();
        if (fail_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
            fail_count++;
        end
    endtask
    task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge ref_clk_in);
        bus_req_in <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk_in);
        bus_req_in.wr <= 1'b0;
    endtask
    task automatic bus_rd(input logic [ADDR_W-1:0] a);
        @(posedge ref_clk_in);
        bus_req_in <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
        @(posedge ref_clk_in);
        bus_req_in.rd <= 1'b0;
        @(negedge ref_clk_in);
        rd_val = reg_rdata_out;
    endtask
    task automatic do_reset();
        @(posedge ref_clk_in);
        rst_b_in <= 1'b0;
        repeat (10) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        exp_pos = 0;
    endtask
    // one excitation cycle is ten full steps of a 500-step turn
    function automatic int incf(input int t, input int c);
        return int'(CYCLE_UNITS) * 50 / res_tab[t][c];
    endfunction
    task automatic step(input logic dual, input logic fwd, input int inc);
        ssel_host_inst.pulse(dual, fwd, 3);
        repeat (2) @(posedge ref_clk_in);
        exp_pos = (exp_pos + (fwd ? inc : int'(CYCLE_UNITS) - inc)) % int'(CYCLE_UNITS);
        @(negedge ref_clk_in);
        chk("position", 32'(exp_pos), 32'(exc_pos_out));
    endtask
    task automatic sc_reset();
        do_reset();
        @(negedge ref_clk_in);
        chk("timing", 32'h1, 32'(timing_out));
        chk("position", 32'h0, 32'(exc_pos_out));
        bus_rd(CFG_ADDR);
        chk("config", 32'h2000, rd_val & 32'h7ff1);
        chk("smooth", 32'h1, 32'(smooth_active_out));
        bus_rd(8'h10);
        chk("unmapped", 32'h0, rd_val);
    endtask
    task automatic sc_tables();
        for (int t = 0; t < 2; t++) begin
            for (int c = 0; c < 16; c++) begin
                bus_wr(CFG_ADDR, 32'(t) | (32'(c) << CFG_CODE1_LSB) | (32'h1 << CFG_SMOOTH_BIT));
                bus_rd(RES_ADDR);
                chk("resolution", 32'(res_tab[t][c]), rd_val);
                chk("smooth", 32'(c <= 6 + t), 32'(smooth_active_out));
            end
        end
        bus_wr(CFG_ADDR, 32'h1 << CFG_HIRES_BIT);
        bus_rd(RES_ADDR);
        chk("hires resolution", 32'd1000, rd_val);
    endtask
    task automatic sc_select();
        do_reset();
        bus_wr(CFG_ADDR, 32'h5 << CFG_CODE2_LSB);
        step(1'b0, 1'b1, incf(0, 0));
        ssel_host_inst.set_select(1'b1);
        bus_rd(STAT_ADDR);
        chk("active code", 32'h5, 32'(rd_val[31:28]));
        step(1'b0, 1'b1, incf(0, 5));
        ssel_host_inst.set_select(1'b0);
        step(1'b0, 1'b0, incf(0, 0));
    endtask
    task automatic sc_dir();
        do_reset();
        bus_wr(CFG_ADDR, 32'h7 << CFG_CODE1_LSB);
        step(1'b0, 1'b0, incf(0, 7));
        chk("timing", 32'h0, 32'(timing_out));
        step(1'b0, 1'b1, incf(0, 7));
        chk("timing", 32'h1, 32'(timing_out));
    endtask
    task automatic sc_dual();
        do_reset();
        bus_wr(CFG_ADDR, (32'h1 << CFG_MODE_BIT) | (32'h3 << CFG_CODE1_LSB));
        step(1'b1, 1'b1, incf(0, 3));
        step(1'b1, 1'b0, incf(0, 3));
        step(1'b1, 1'b0, incf(0, 3));
        ssel_host_inst.both_lines(3);
        exp_pos = (exp_pos + int'(CYCLE_UNITS) - incf(0, 3)) % int'(CYCLE_UNITS);
        @(negedge ref_clk_in);
        chk("position", 32'(exp_pos), 32'(exc_pos_out));
        bus_rd(STAT_ADDR);
        chk("both lines flag", 32'h1, 32'(rd_val[STAT_BOTH_BIT]));
        bus_wr(STAT_ADDR, 32'h1 << STAT_BOTH_BIT);
        bus_rd(STAT_ADDR);
        chk("both lines cleared", 32'h0, 32'(rd_val[STAT_BOTH_BIT]));
        bus_rd(CNT_ADDR);
        chk("pulse count", 32'd4, rd_val);
    endtask
    task automatic sc_smooth();
        int n;
        logic [POS_W-1:0] last;
        do_reset();
        n = 0;
        last = '0;
        fork
            ssel_host_inst.pulse(1'b0, 1'b1, 3);
            repeat (400) begin
                @(negedge ref_clk_in);
                if (exc_pos_out !== last) begin
                    n++;
                    last = exc_pos_out;
                end
            end
            begin
                // rewrite of the same settings while microsteps are still queued
                repeat (60) @(posedge ref_clk_in);
                bus_wr(CFG_ADDR, 32'h1 << CFG_SMOOTH_BIT);
            end
        join
        chk("microsteps", 32'd16, 32'(n));
        bus_rd(STAT_ADDR);
        chk("changed while moving", 32'h1, 32'(rd_val[STAT_RUNCHG_BIT]));
        chk("position", 32'(incf(0, 0)), 32'(exc_pos_out));
    endtask
    initial begin
        rst_b_in = 1'b0;
        bus_req_in = '0;
        sc_reset();
        sc_tables();
        sc_select();
        sc_dir();
        sc_dual();
        sc_smooth();
        close_out();
    end
endmodule
bind ssel_top ssel_top_props ssel_top_props_inst (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .bus_req_in(bus_req_in), .reg_rdata_out(reg_rdata_out), .pins_in(pins_in), .exc_pos_out(exc_pos_out),
    .timing_out(timing_out), .smooth_active_out(smooth_active_out));
